//--- logic/adc_sync_defines.vh
// Purpose: register indices, masks and timing counts.
// Assumes: byte address of a register is four times its index.
// Notes:   definitions only.
`ifndef ADC_SYNC_DEFINES_VH
`define ADC_SYNC_DEFINES_VH

// ==========================================================
// register indices
`define IDX_CONTROL_A      6'h00
`define IDX_REF_CONTROL    6'h01
`define IDX_AVG_CONTROL    6'h02
`define IDX_SAMPLE_TIME    6'h03
`define IDX_CONTROL_B      6'h04
`define IDX_WINDOW_CTRL    6'h08
`define IDX_SW_TRIGGER     6'h0c
`define IDX_INPUT_SELECT   6'h10
`define IDX_EVENT_CONTROL  6'h14
`define IDX_IRQ_EN_CLEAR   6'h16
`define IDX_IRQ_EN_SET     6'h17
`define IDX_IRQ_FLAGS      6'h18
`define IDX_SYNC_STATUS    6'h19
`define IDX_CONV_RESULT    6'h1a
`define IDX_WIN_LOWER      6'h1c
`define IDX_WIN_UPPER      6'h20
`define IDX_GAIN_CORR      6'h24
`define IDX_OFFSET_CORR    6'h26
`define IDX_CALIBRATION    6'h28
`define IDX_DEBUG_CONTROL  6'h2a

// ==========================================================
// writable-bit masks, reserved bits read zero
`define MASK_CONTROL_A     32'h0000_0006
`define MASK_REF_CONTROL   32'h0000_008f
`define MASK_AVG_CONTROL   32'h0000_007f
`define MASK_SAMPLE_TIME   32'h0000_003f
`define MASK_CONTROL_B     32'h0000_073f
`define MASK_WINDOW_CTRL   32'h0000_0007
`define MASK_SW_TRIGGER    32'h0000_0003
`define MASK_INPUT_SELECT  32'h0fff_1f1f
`define MASK_EVENT_CONTROL 32'h0000_0033
`define MASK_CORR          32'h0000_0fff
`define MASK_CALIBRATION   32'h0000_07ff
`define MASK_DEBUG_CONTROL 32'h0000_0001
`define MASK_THRESHOLD     32'h0000_ffff

// ==========================================================
// field positions
`define BIT_SOFT_RESET     0
`define BIT_ENABLE         1
`define BIT_TRIG_FLUSH     0
`define BIT_TRIG_START     1
`define BIT_SYNC_BUSY      7
`define IRQ_RESULT_READY   0
`define IRQ_OVERRUN        1
`define IRQ_WINDOW_MATCH   2
`define IRQ_CROSSING_DONE  3
`define IRQ_MASK_ALL       4'hf

// ==========================================================
// timing: converter clock edges a crossing takes
`define CROSS_EDGES        2'h2

`endif

//--- logic/sync_rise.v
// Purpose: two-flop synchroniser with rising-edge detect per bit.
// Assumes: inputs are levels from another clock domain.
// Notes:   first stage is read only by the second stage.
`timescale 1ns/100ps
module sync_rise #(
  parameter W = 1
) (
  input  wire         mclk_i,
  input  wire         rst_i,
  input  wire [W-1:0] async_i,
  output wire [W-1:0] level_o,
  output wire [W-1:0] rise_o
);
  reg [W-1:0] meta_q;
  reg [W-1:0] stab_q;
  reg [W-1:0] last_q;

  always @(posedge mclk_i) begin
    if (rst_i) begin
      meta_q <= {W{1'b0}};
      stab_q <= {W{1'b0}};
      last_q <= {W{1'b0}};
    end else begin
      meta_q <= async_i;
      stab_q <= meta_q;
      last_q <= stab_q;
    end
  end

  assign level_o = stab_q;
  assign rise_o  = stab_q & ~last_q;
endmodule // sync_rise

//--- logic/adc_register_sync_bridge.v
// Purpose: converter register file with crossings
//          into the core clock domain.
// Assumes: Avalon-MM slave, 32-bit data, one register per word.
// Notes:   core clock is sampled, not used as a clock.
// Contract
// - busy set at start, cleared when crossing ends
// - crossing done flag raised on completion, except for a soft reset
// - synced access while busy waits on bus
// - stalled access completes correctly after release
// - soft reset and enable writes are synced
// - control_b, trigger, window, input, thresholds synced
// - trigger, input, result reads synced; only result captured from core
// - interrupts stay pending during stall
// - soft reset clears all but debug, disables
// - soft reset bit overrides rest of write
// - enable reads back written value at once
`timescale 1ns/100ps
`include "adc_sync_defines.vh"
module adc_register_sync_bridge (
  input  wire        mclk_i,
  input  wire        rst_i,
  input  wire [7:0]  address_i,
  input  wire        read_i,
  input  wire        write_i,
  input  wire [3:0]  byteenable_i,
  input  wire [31:0] writedata_i,
  output wire [31:0] readdata_o,
  output wire        waitrequest_o,
  input  wire        converter_core_clock_i,
  input  wire [15:0] conv_result_i,
  input  wire [2:0]  conv_events_i,
  output wire        conv_enable_o,
  output wire        conv_run_standby_o,
  output wire [15:0] conv_control_b_o,
  output wire [2:0]  conv_window_mode_o,
  output wire [31:0] conv_input_select_o,
  output wire [15:0] conv_win_lower_o,
  output wire [15:0] conv_win_upper_o,
  output wire        conv_start_o,
  output wire        conv_flush_o,
  output wire        irq_o
);

  // ========================================================
  // synchronisers
  wire        core_edge;
  wire [2:0]  ev_rise;
  wire [15:0] result_s;

  sync_rise #(.W(1)) u_core_clk (
    .mclk_i  (mclk_i),
    .rst_i   (rst_i),
    .async_i (converter_core_clock_i),
    .level_o (),
    .rise_o  (core_edge)
  );

  sync_rise #(.W(3)) u_events (
    .mclk_i  (mclk_i),
    .rst_i   (rst_i),
    .async_i (conv_events_i),
    .level_o (),
    .rise_o  (ev_rise)
  );

  sync_rise #(.W(16)) u_result (
    .mclk_i  (mclk_i),
    .rst_i   (rst_i),
    .async_i (conv_result_i),
    .level_o (result_s),
    .rise_o  ()
  );

  // ========================================================
  // state
  reg        waitreq_q;
  reg [31:0] rdata_q;
  reg        busy_q;
  reg        rd_pend_q;
  reg [5:0]  rd_idx_q;
  reg [1:0]  cnt_q;
  reg        soft_reset_bit_q;
  reg [3:0]  flags_q;
  reg [3:0]  mask_q;
  reg        irq_q;
  reg [31:0] ctrl_a_q;
  reg [31:0] ref_q;
  reg [31:0] avg_q;
  reg [31:0] samp_q;
  reg [31:0] ctrl_b_q;
  reg [31:0] win_ctrl_q;
  reg [31:0] trig_q;
  reg [31:0] in_sel_q;
  reg [31:0] ev_ctrl_q;
  reg [31:0] win_lo_q;
  reg [31:0] win_hi_q;
  reg [31:0] gain_q;
  reg [31:0] offs_q;
  reg [31:0] calibration_q;
  reg [31:0] dbg_q;
  reg        en_app_q;
  reg        stdby_app_q;
  reg [15:0] ctrl_b_app_q;
  reg [2:0]  win_mode_app_q;
  reg [31:0] in_sel_app_q;
  reg [15:0] win_lo_app_q;
  reg [15:0] win_hi_app_q;
  reg        start_q;
  reg        flush_q;

  // ========================================================
  // decode
  wire [5:0] idx = address_i[7:2];
  wire       req = (read_i | write_i) & waitreq_q & ~rd_pend_q;
  wire       complete = busy_q & core_edge & (cnt_q == `CROSS_EDGES - 2'h1);

  reg        sync_wr;
  reg        sync_rd;
  reg [31:0] rd_mux;
  reg [31:0] flag_clr;
  reg [3:0]  flags_d;

  always @* begin
    case (idx)
      `IDX_CONTROL_A,
      `IDX_CONTROL_B,
      `IDX_WINDOW_CTRL,
      `IDX_SW_TRIGGER,
      `IDX_INPUT_SELECT,
      `IDX_WIN_LOWER,
      `IDX_WIN_UPPER:     sync_wr = write_i;
      default:            sync_wr = 1'b0;
    endcase
    case (idx)
      `IDX_SW_TRIGGER,
      `IDX_INPUT_SELECT,
      `IDX_CONV_RESULT:   sync_rd = read_i;
      default:            sync_rd = 1'b0;
    endcase
  end

  // direct reads
  always @* begin
    case (idx)
      `IDX_CONTROL_A:     rd_mux = ctrl_a_q | {31'h0, soft_reset_bit_q};
      `IDX_REF_CONTROL:   rd_mux = ref_q;
      `IDX_AVG_CONTROL:   rd_mux = avg_q;
      `IDX_SAMPLE_TIME:   rd_mux = samp_q;
      `IDX_CONTROL_B:     rd_mux = ctrl_b_q;
      `IDX_WINDOW_CTRL:   rd_mux = win_ctrl_q;
      `IDX_EVENT_CONTROL: rd_mux = ev_ctrl_q;
      `IDX_IRQ_EN_CLEAR,
      `IDX_IRQ_EN_SET:    rd_mux = {28'h0, mask_q};
      `IDX_IRQ_FLAGS:     rd_mux = {28'h0, flags_q};
      `IDX_SYNC_STATUS:   rd_mux = {24'h0, busy_q, 7'h00};
      `IDX_WIN_LOWER:     rd_mux = win_lo_q;
      `IDX_WIN_UPPER:     rd_mux = win_hi_q;
      `IDX_GAIN_CORR:     rd_mux = gain_q;
      `IDX_OFFSET_CORR:   rd_mux = offs_q;
      `IDX_CALIBRATION:   rd_mux = calibration_q;
      `IDX_DEBUG_CONTROL: rd_mux = dbg_q;
      default:            rd_mux = 32'h0000_0000;
    endcase
  end

  // a set beats a clear in the same cycle
  always @* begin
    flag_clr = 32'h0000_0000;
    if (req & write_i & ~sync_wr & (idx == `IDX_IRQ_FLAGS) &
        byteenable_i[0])
      flag_clr = writedata_i;
    flags_d = (flags_q & ~flag_clr[3:0]) |
              {complete & ~soft_reset_bit_q, ev_rise};
  end

  function [31:0] merge;
    input [31:0] old;
    input [31:0] wd;
    input [3:0]  be;
    input [31:0] msk;
    reg   [31:0] lanes;
    integer      i;
    begin
      lanes = 32'h0000_0000;
      for (i = 0; i < 4; i = i + 1)
        lanes[i*8 +: 8] = {8{be[i]}};
      merge = ((old & ~lanes) | (wd & lanes)) & msk;
    end
  endfunction

  // ========================================================
  // main sequential logic
  always @(posedge mclk_i) begin
    if (rst_i) begin
      waitreq_q      <= 1'b1;
      rdata_q        <= 32'h0000_0000;
      busy_q         <= 1'b0;
      rd_pend_q      <= 1'b0;
      rd_idx_q       <= 6'h00;
      cnt_q          <= 2'h0;
      soft_reset_bit_q        <= 1'b0;
      flags_q        <= 4'h0;
      mask_q         <= 4'h0;
      irq_q          <= 1'b0;
      ctrl_a_q       <= 32'h0000_0000;
      ref_q          <= 32'h0000_0000;
      avg_q          <= 32'h0000_0000;
      samp_q         <= 32'h0000_0000;
      ctrl_b_q       <= 32'h0000_0000;
      win_ctrl_q     <= 32'h0000_0000;
      trig_q         <= 32'h0000_0000;
      in_sel_q       <= 32'h0000_0000;
      ev_ctrl_q      <= 32'h0000_0000;
      win_lo_q       <= 32'h0000_0000;
      win_hi_q       <= 32'h0000_0000;
      gain_q         <= 32'h0000_0000;
      offs_q         <= 32'h0000_0000;
      calibration_q        <= 32'h0000_0000;
      dbg_q          <= 32'h0000_0000;
      en_app_q       <= 1'b0;
      stdby_app_q    <= 1'b0;
      ctrl_b_app_q   <= 16'h0000;
      win_mode_app_q <= 3'h0;
      in_sel_app_q   <= 32'h0000_0000;
      win_lo_app_q   <= 16'h0000;
      win_hi_app_q   <= 16'h0000;
      start_q        <= 1'b0;
      flush_q        <= 1'b0;
    end else begin
      start_q <= 1'b0;
      flush_q <= 1'b0;
      flags_q <= flags_d;
      irq_q   <= |(flags_d & mask_q);

      // ------------------------------------------------------
      // crossing into the converter domain
      if (busy_q & core_edge)
        cnt_q <= cnt_q + 2'h1;
      if (complete) begin
        busy_q <= 1'b0;
        if (soft_reset_bit_q) begin
          // all but debug control back to initial
          soft_reset_bit_q        <= 1'b0;
          flags_q        <= 4'h0;
          mask_q         <= 4'h0;
          irq_q          <= 1'b0;
          ctrl_a_q       <= 32'h0000_0000;
          ref_q          <= 32'h0000_0000;
          avg_q          <= 32'h0000_0000;
          samp_q         <= 32'h0000_0000;
          ctrl_b_q       <= 32'h0000_0000;
          win_ctrl_q     <= 32'h0000_0000;
          trig_q         <= 32'h0000_0000;
          in_sel_q       <= 32'h0000_0000;
          ev_ctrl_q      <= 32'h0000_0000;
          win_lo_q       <= 32'h0000_0000;
          win_hi_q       <= 32'h0000_0000;
          gain_q         <= 32'h0000_0000;
          offs_q         <= 32'h0000_0000;
          calibration_q        <= 32'h0000_0000;
          en_app_q       <= 1'b0;
          stdby_app_q    <= 1'b0;
          ctrl_b_app_q   <= 16'h0000;
          win_mode_app_q <= 3'h0;
          in_sel_app_q   <= 32'h0000_0000;
          win_lo_app_q   <= 16'h0000;
          win_hi_app_q   <= 16'h0000;
        end else begin
          // all synced copies land together
          en_app_q       <= ctrl_a_q[`BIT_ENABLE];
          stdby_app_q    <= ctrl_a_q[2];
          ctrl_b_app_q   <= ctrl_b_q[15:0];
          win_mode_app_q <= win_ctrl_q[2:0];
          in_sel_app_q   <= in_sel_q;
          win_lo_app_q   <= win_lo_q[15:0];
          win_hi_app_q   <= win_hi_q[15:0];
          start_q        <= trig_q[`BIT_TRIG_START];
          flush_q        <= trig_q[`BIT_TRIG_FLUSH];
          trig_q         <= 32'h0000_0000;
        end
      end

      // ------------------------------------------------------
      // bus side
      if (~waitreq_q) begin
        waitreq_q <= 1'b1;
      end else if (rd_pend_q & complete) begin
        // strobes have fired by now, so trigger reads zero
        case (rd_idx_q)
          `IDX_INPUT_SELECT: rdata_q <= in_sel_app_q;
          `IDX_CONV_RESULT:  rdata_q <= {16'h0000, result_s};
          default:           rdata_q <= 32'h0000_0000;
        endcase
        rd_pend_q <= 1'b0;
        waitreq_q <= 1'b0;
      end else if (req) begin
        if ((sync_wr | sync_rd) & busy_q) begin
          // hold the transfer until the crossing ends
          waitreq_q <= 1'b1;
        end else if (sync_rd) begin
          busy_q    <= 1'b1;
          cnt_q     <= 2'h0;
          rd_pend_q <= 1'b1;
          rd_idx_q  <= idx;
        end else begin
          waitreq_q <= 1'b0;
          rdata_q   <= read_i ? rd_mux : 32'h0000_0000;
          if (sync_wr) begin
            busy_q <= 1'b1;
            cnt_q  <= 2'h0;
          end
          if (write_i) begin
            case (idx)
              `IDX_CONTROL_A:
                if (byteenable_i[0] & writedata_i[`BIT_SOFT_RESET])
                  soft_reset_bit_q <= 1'b1;
                else
                  ctrl_a_q <= merge(ctrl_a_q, writedata_i,
                                    byteenable_i, `MASK_CONTROL_A);
              `IDX_REF_CONTROL:
                ref_q <= merge(ref_q, writedata_i, byteenable_i,
                               `MASK_REF_CONTROL);
              `IDX_AVG_CONTROL:
                avg_q <= merge(avg_q, writedata_i, byteenable_i,
                               `MASK_AVG_CONTROL);
              `IDX_SAMPLE_TIME:
                samp_q <= merge(samp_q, writedata_i, byteenable_i,
                                `MASK_SAMPLE_TIME);
              `IDX_CONTROL_B:
                ctrl_b_q <= merge(ctrl_b_q, writedata_i, byteenable_i,
                                  `MASK_CONTROL_B);
              `IDX_WINDOW_CTRL:
                win_ctrl_q <= merge(win_ctrl_q, writedata_i,
                                    byteenable_i, `MASK_WINDOW_CTRL);
              `IDX_SW_TRIGGER:
                trig_q <= merge(trig_q, writedata_i, byteenable_i,
                                `MASK_SW_TRIGGER);
              `IDX_INPUT_SELECT:
                in_sel_q <= merge(in_sel_q, writedata_i, byteenable_i,
                                  `MASK_INPUT_SELECT);
              `IDX_EVENT_CONTROL:
                ev_ctrl_q <= merge(ev_ctrl_q, writedata_i, byteenable_i,
                                   `MASK_EVENT_CONTROL);
              `IDX_IRQ_EN_CLEAR:
                if (byteenable_i[0])
                  mask_q <= mask_q & ~writedata_i[3:0];
              `IDX_IRQ_EN_SET:
                if (byteenable_i[0])
                  mask_q <= mask_q | writedata_i[3:0];
              `IDX_WIN_LOWER:
                win_lo_q <= merge(win_lo_q, writedata_i, byteenable_i,
                                  `MASK_THRESHOLD);
              `IDX_WIN_UPPER:
                win_hi_q <= merge(win_hi_q, writedata_i, byteenable_i,
                                  `MASK_THRESHOLD);
              `IDX_GAIN_CORR:
                gain_q <= merge(gain_q, writedata_i, byteenable_i,
                                `MASK_CORR);
              `IDX_OFFSET_CORR:
                offs_q <= merge(offs_q, writedata_i, byteenable_i,
                                `MASK_CORR);
              `IDX_CALIBRATION:
                calibration_q <= merge(calibration_q, writedata_i, byteenable_i,
                                 `MASK_CALIBRATION);
              `IDX_DEBUG_CONTROL:
                dbg_q <= merge(dbg_q, writedata_i, byteenable_i,
                               `MASK_DEBUG_CONTROL);
              default: ;
            endcase
          end
        end
      end
    end
  end

  // ========================================================
  // outputs
  assign readdata_o          = rdata_q;
  assign waitrequest_o       = waitreq_q;
  assign conv_enable_o       = en_app_q;
  assign conv_run_standby_o  = stdby_app_q;
  assign conv_control_b_o    = ctrl_b_app_q;
  assign conv_window_mode_o  = win_mode_app_q;
  assign conv_input_select_o = in_sel_app_q;
  assign conv_win_lower_o    = win_lo_app_q;
  assign conv_win_upper_o    = win_hi_app_q;
  assign conv_start_o        = start_q;
  assign conv_flush_o        = flush_q;
  assign irq_o               = irq_q;
endmodule // adc_register_sync_bridge

//--- bench/converter_core_model.sv
// Purpose: core side: free core clock, result, events.
// Assumes: bridge samples the core clock.
// Notes:   slow_i stretches crossings.
`timescale 1ns/100ps
module converter_core_model (
  input  wire        slow_i,
  input  wire [15:0] sample_i,
  input  wire [2:0]  event_req_i,
  output reg         core_clk_o,
  output reg  [15:0] result_o,
  output reg  [2:0]  events_o
);
  // ==========================================================
  // core clock and outputs
  initial {core_clk_o, result_o, events_o} = 20'h00000;
  // both well below half the bus rate
  always #(slow_i ? 47 : 13) core_clk_o = ~core_clk_o;
  always @(posedge core_clk_o) begin
    result_o <= sample_i;
    events_o <= event_req_i;
  end
endmodule // converter_core_model

//--- bench/adc_register_sync_bridge_properties.sv
// Purpose: port-level checks of the bridge.
// Assumes: single bus clock; core clock only sampled.
// Notes:   crossing windows bounded by counts.
`timescale 1ns/100ps
`include "adc_sync_defines.vh"
module adc_register_sync_bridge_properties (
  input wire        mclk_i,
  input wire        rst_i,
  input wire [7:0]  address_i,
  input wire        read_i,
  input wire        write_i,
  input wire [31:0] readdata_o,
  input wire        waitrequest_o,
  input wire        conv_enable_o,
  input wire [15:0] conv_control_b_o,
  input wire [31:0] conv_input_select_o,
  input wire        conv_start_o,
  input wire        irq_o
);
  // ==========================================================
  // decode and crossing age
  wire [5:0] idx = address_i[7:2];
  wire sync_w = idx == `IDX_CONTROL_A || idx == `IDX_CONTROL_B ||
    idx == `IDX_WINDOW_CTRL || idx == `IDX_SW_TRIGGER ||
    idx == `IDX_INPUT_SELECT || idx == `IDX_WIN_LOWER ||
    idx == `IDX_WIN_UPPER;
  wire sync_r = idx == `IDX_SW_TRIGGER || idx == `IDX_INPUT_SELECT ||
    idx == `IDX_CONV_RESULT;
  wire unmapped = idx == 6'h05 || idx == 6'h3f;
  reg  [9:0] since_sync_q;
  always @(posedge mclk_i) begin
    if (rst_i)
      since_sync_q <= 10'h3ff;
    else if (write_i && !waitrequest_o && sync_w)
      since_sync_q <= 10'h000;
    else if (since_sync_q != 10'h3ff)
      since_sync_q <= since_sync_q + 10'h001;
  end
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  // ==========================================================
  // assertions
  a_wait_one_cycle: assert property (!waitrequest_o |=> waitrequest_o)
    else $error("waitrequest low longer than one cycle");
  a_answer_bounded: assert property ($rose(read_i || write_i) |->
    ##[1:400] !waitrequest_o) else $error("request never answered");
  a_direct_no_stall: assert property (((read_i && !sync_r) ||
    (write_i && !sync_w)) && waitrequest_o |=> !waitrequest_o)
    else $error("direct access stalled");
  a_sync_read_waits: assert property ($rose(read_i) && sync_r |=>
    waitrequest_o [*2]) else $error("synced read answered too soon");
  a_unmapped_zero: assert property (read_i && !waitrequest_o &&
    unmapped |-> readdata_o == 32'h0) else $error("unmapped read not zero");
  a_trigger_reads_zero: assert property (read_i && !waitrequest_o &&
    idx == `IDX_SW_TRIGGER |-> readdata_o == 32'h0)
    else $error("trigger read not zero");
  a_start_single: assert property (conv_start_o |=> !conv_start_o)
    else $error("start pulse longer than one cycle");
  a_clean_release: assert property ($fell(rst_i) |-> waitrequest_o &&
    !irq_o && !conv_enable_o && readdata_o == 32'h0)
    else $error("outputs not idle after reset");
  a_enable_after_cross: assert property ($changed(conv_enable_o) |->
    since_sync_q >= 10'h002 && since_sync_q <= 10'h190)
    else $error("enable changed without a crossing");
  a_config_after_cross: assert property (($changed(conv_control_b_o) ||
    $changed(conv_input_select_o) || conv_start_o) |->
    since_sync_q >= 10'h002 && since_sync_q <= 10'h190)
    else $error("applied value changed without a crossing");
  c_stalled_write: cover property (write_i && sync_w && waitrequest_o [*3]);
  c_sync_read_done: cover property (read_i && sync_r && !waitrequest_o);
  c_irq_raised: cover property ($rose(irq_o));
endmodule // adc_register_sync_bridge_properties

bind adc_register_sync_bridge adc_register_sync_bridge_properties
  adc_register_sync_bridge_properties_inst (.mclk_i(mclk_i), .rst_i(rst_i),
  .address_i(address_i), .read_i(read_i), .write_i(write_i),
  .readdata_o(readdata_o), .waitrequest_o(waitrequest_o),
  .conv_enable_o(conv_enable_o), .conv_control_b_o(conv_control_b_o),
  .conv_input_select_o(conv_input_select_o),
  .conv_start_o(conv_start_o), .irq_o(irq_o));

//--- bench/adc_register_sync_bridge_tb.sv
// Purpose: self-checking bench of the bridge.
// Assumes: register model kept in an array.
// Notes:   core clock switched for fast and slow crossings.
`timescale 1ns/100ps
`include "adc_sync_defines.vh"
module adc_register_sync_bridge_tb;
  reg         mclk_i = 1'b0;
  reg         rst_i = 1'b1;
  reg  [7:0]  address_i = 8'h00;
  reg         read_i = 1'b0;
  reg         write_i = 1'b0;
  reg  [3:0]  byteenable_i = 4'hf;
  reg  [31:0] writedata_i = 32'h0;
  reg         slow = 1'b0;
  reg  [15:0] sample = 16'h0000;
  reg  [2:0]  ev_req = 3'h0;
  wire [31:0] readdata_o, insel;
  wire        waitrequest_o, core_clk, conv_enable_o, conv_start_o;
  wire        conv_flush_o, irq_o, stdby;
  wire [15:0] result, ctlb, wlo, whi;
  wire [2:0]  events, wmode;
  integer     n_fail = 0, n_tests = 0, seed = 11, cyc, i, s, w;
  integer     n_start = 0, n_flush = 0;
  reg  [31:0] rd, v;
  reg  [5:0]  k;
  reg  [31:0] model [0:63];
  localparam [47:0] DIR = {`IDX_REF_CONTROL, `IDX_AVG_CONTROL,
    `IDX_SAMPLE_TIME, `IDX_EVENT_CONTROL, `IDX_GAIN_CORR,
    `IDX_OFFSET_CORR, `IDX_CALIBRATION, `IDX_DEBUG_CONTROL};
  localparam [29:0] SYN = {`IDX_CONTROL_B, `IDX_WINDOW_CTRL,
    `IDX_INPUT_SELECT, `IDX_WIN_LOWER, `IDX_WIN_UPPER};

  adc_register_sync_bridge adc_register_sync_bridge_inst (
    .mclk_i(mclk_i), .rst_i(rst_i), .address_i(address_i),
    .read_i(read_i), .write_i(write_i), .byteenable_i(byteenable_i),
    .writedata_i(writedata_i), .readdata_o(readdata_o),
    .waitrequest_o(waitrequest_o), .converter_core_clock_i(core_clk),
    .conv_result_i(result), .conv_events_i(events),
    .conv_enable_o(conv_enable_o), .conv_run_standby_o(stdby),
    .conv_control_b_o(ctlb), .conv_window_mode_o(wmode),
    .conv_input_select_o(insel), .conv_win_lower_o(wlo),
    .conv_win_upper_o(whi), .conv_start_o(conv_start_o),
    .conv_flush_o(conv_flush_o), .irq_o(irq_o));
  converter_core_model converter_core_model_inst (.slow_i(slow),
    .sample_i(sample), .event_req_i(ev_req), .core_clk_o(core_clk),
    .result_o(result), .events_o(events));

  // ==========================================================
  // clock, counters, watchdog
  always #2.5 mclk_i = ~mclk_i;
  always @(posedge mclk_i) begin
    if (conv_start_o === 1'b1) n_start = n_start + 1;
    if (conv_flush_o === 1'b1) n_flush = n_flush + 1;
  end
  initial begin
    #250000;
    n_fail = n_fail + 1;
    stop_test;
  end

  // ==========================================================
  // model, bus tasks, compare
  function [31:0] mask_of(input [5:0] x);
    case (x)
      `IDX_REF_CONTROL:   mask_of = `MASK_REF_CONTROL;
      `IDX_AVG_CONTROL:   mask_of = `MASK_AVG_CONTROL;
      `IDX_SAMPLE_TIME:   mask_of = `MASK_SAMPLE_TIME;
      `IDX_CONTROL_B:     mask_of = `MASK_CONTROL_B;
      `IDX_WINDOW_CTRL:   mask_of = `MASK_WINDOW_CTRL;
      `IDX_INPUT_SELECT:  mask_of = `MASK_INPUT_SELECT;
      `IDX_EVENT_CONTROL: mask_of = `MASK_EVENT_CONTROL;
      `IDX_GAIN_CORR:     mask_of = `MASK_CORR;
      `IDX_OFFSET_CORR:   mask_of = `MASK_CORR;
      `IDX_CALIBRATION:   mask_of = `MASK_CALIBRATION;
      `IDX_DEBUG_CONTROL: mask_of = `MASK_DEBUG_CONTROL;
      default:            mask_of = `MASK_THRESHOLD;
    endcase
  endfunction
  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("ERROR t=%0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task bus(input wr, input [5:0] x, input [31:0] wd, input [3:0] be);
    begin
      @(posedge mclk_i);
      address_i <= {x, 2'b00};
      write_i <= wr;
      read_i <= !wr;
      writedata_i <= wd;
      byteenable_i <= be;
      cyc = 0;
      do begin
        @(posedge mclk_i);
        cyc = cyc + 1;
      end while (waitrequest_o !== 1'b0);
      rd = readdata_o;
      write_i <= 1'b0;
      read_i <= 1'b0;
    end
  endtask
  task wr(input [5:0] x, input [31:0] wd, input [3:0] be);
    reg [31:0] bm;
    begin
      bm = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
      bus(1'b1, x, wd, be);
      model[x] = ((model[x] & ~bm) | (wd & bm)) & mask_of(x);
    end
  endtask
  task wait_idle;
    begin
      w = 0;
      do begin
        bus(1'b0, `IDX_SYNC_STATUS, 32'h0, 4'hf);
        w = w + 1;
      end while (rd[7] !== 1'b0);
    end
  endtask
  task stop_test;
    begin
      $display("comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask

  // ==========================================================
  // scenarios
  initial begin
    for (i = 0; i < 64; i = i + 1) model[i] = 32'h0;
    repeat (16) @(posedge mclk_i);
    rst_i <= 1'b0;
    wr(6'h05, 32'hffff_ffff, 4'hf);
    for (i = 0; i < 16; i = i + 1) begin
      k = DIR[(i % 8) * 6 +: 6];
      if (i < 8) bus(1'b0, k, 32'h0, 4'hf);
      if (i < 8) chk(rd, 32'h0);
      wr(k, $random(seed), (i < 8) ? 4'hf : 4'h1);
      chk(cyc, 2);
      bus(1'b0, k, 32'h0, 4'hf);
      chk(rd, model[k]);
    end
    bus(1'b0, 6'h05, 32'h0, 4'hf);
    chk(rd, 32'h0);
    for (s = 0; s < 2; s = s + 1) begin
      slow <= s[0];
      for (i = 0; i < 5; i = i + 1) begin
        wr(SYN[i * 6 +: 6], $random(seed), 4'hf);
        if (i > 0) chk({31'h0, cyc > 2}, 1);
      end
      bus(1'b0, `IDX_SYNC_STATUS, 32'h0, 4'hf);
      chk(rd, 32'h80);
      wait_idle;
      for (i = 0; i < 5; i = i + 1) begin
        bus(1'b0, SYN[i * 6 +: 6], 32'h0, 4'hf);
        chk(rd, model[SYN[i * 6 +: 6]]);
      end
      chk({16'h0, ctlb}, model[`IDX_CONTROL_B]);
      chk({29'h0, wmode}, model[`IDX_WINDOW_CTRL]);
      chk(insel, model[`IDX_INPUT_SELECT]);
      chk({wlo, whi}, {model[`IDX_WIN_LOWER][15:0],
        model[`IDX_WIN_UPPER][15:0]});
      bus(1'b0, `IDX_IRQ_FLAGS, 32'h0, 4'hf);
      chk(rd, 32'h8);
      bus(1'b1, `IDX_IRQ_FLAGS, 32'h8, 4'hf);
    end
    bus(1'b1, `IDX_IRQ_EN_SET, 32'h9, 4'hf);
    bus(1'b1, `IDX_CONTROL_A, 32'h6, 4'hf);
    bus(1'b0, `IDX_CONTROL_A, 32'h0, 4'hf);
    chk(rd, 32'h6);
    chk({31'h0, conv_enable_o}, 0);
    fork
      wr(`IDX_WINDOW_CTRL, 32'h5, 4'hf);
      begin
        repeat (3) @(posedge mclk_i);
        ev_req <= 3'h1;
      end
    join
    chk({31'h0, cyc > 2}, 1);
    ev_req <= 3'h0;
    wait_idle;
    chk({30'h0, stdby, conv_enable_o}, 3);
    bus(1'b0, `IDX_IRQ_FLAGS, 32'h0, 4'hf);
    chk(rd, 32'h9);
    chk({31'h0, irq_o}, 1);
    bus(1'b1, `IDX_IRQ_EN_CLEAR, 32'h9, 4'hf);
    bus(1'b0, `IDX_IRQ_EN_SET, 32'h0, 4'hf);
    chk({rd[3:0], 3'h0, irq_o}, 0);
    bus(1'b1, `IDX_IRQ_EN_SET, 32'h1, 4'hf);
    bus(1'b1, `IDX_IRQ_FLAGS, 32'h9, 4'hf);
    @(posedge mclk_i);
    chk({31'h0, irq_o}, 0);
    slow <= 1'b0;
    for (i = 1; i < 3; i = i + 1) begin
      bus(1'b1, `IDX_SW_TRIGGER, i, 4'hf);
      wait_idle;
    end
    chk(n_flush * 2 + n_start, 3);
    bus(1'b0, `IDX_SW_TRIGGER, 32'h0, 4'hf);
    chk(rd, 32'h0);
    sample <= $random(seed);
    repeat (40) @(posedge mclk_i);
    bus(1'b0, `IDX_CONV_RESULT, 32'h0, 4'hf);
    chk(rd, {16'h0, sample});
    chk({31'h0, cyc > 2}, 1);
    slow <= 1'b1;
    bus(1'b1, `IDX_CONTROL_A, 32'h1, 4'hf);
    bus(1'b0, `IDX_CONTROL_A, 32'h0, 4'hf);
    chk(rd, 32'h7);
    wait_idle;
    bus(1'b0, `IDX_CONTROL_A, 32'h0, 4'hf);
    chk({rd[30:0], conv_enable_o}, 0);
    bus(1'b0, `IDX_IRQ_FLAGS, 32'h0, 4'hf);
    chk(rd, 32'h0);
    for (i = 0; i < 8; i = i + 1) begin
      k = DIR[i * 6 +: 6];
      bus(1'b0, k, 32'h0, 4'hf);
      chk(rd, (k == `IDX_DEBUG_CONTROL) ? model[k] : 32'h0);
    end
    chk({16'h0, ctlb}, 0);
    stop_test;
  end
endmodule // adc_register_sync_bridge_tb
